/* aes_cbc_datapath.sv */
// The register addresses and register access over Avalon-MM were chosen for this implementation.
`timescale 1ns/100ps
// What this block does
// - Encrypt mode 0x01 XORs input with chain
// - Decrypt mode 0x02 XORs output with chain
// - Direction bit 2: one encrypts, zero decrypts
// - Enable bit 3 starts; clearing it disables
// - Key size codes 00/01/10: 16/24/32 bytes
// - Writing 0x00 to configuration clears enable and byte counters, and done unless a block completes that cycle
// - Done flag bit 5 marks completion
// - Sixteen result bytes are read in order
// - Later blocks chain previous ciphertext automatically
// - Done is sticky until a configuration write clears bit 5
// - Busy flag bit 4 during an operation
module aes_cbc_datapath (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [aes_cbc_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [aes_cbc_pkg::DATA_W-1:0] avs_writedata,
  input wire logic [aes_cbc_pkg::BE_W-1:0] avs_byteenable,
  output logic [aes_cbc_pkg::DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  output logic done_out,
  output logic busy_out
);
  import aes_cbc_pkg::*;

  logic wait_reg, wait_next;
  logic [DATA_W-1:0] rdata_reg, rdata_next;
  logic [1:0] key_length_select_reg, key_length_select_next;
  logic enc_reg, enc_next;
  logic en_reg, en_next;
  logic busy_reg, busy_next;
  logic done_reg, done_next;
  logic [2:0] dpc_reg, dpc_next;
  logic [127:0] bin_reg, bin_next;
  logic [4:0] bin_cnt_reg, bin_cnt_next;
  logic [127:0] chain_reg, chain_next;
  logic [3:0] xin_cnt_reg, xin_cnt_next;
  logic [255:0] key_reg, key_next;
  logic [5:0] kin_cnt_reg, kin_cnt_next;
  logic [127:0] res_reg, res_next;
  logic [3:0] rd_cnt_reg, rd_cnt_next;
  logic [127:0] hold_reg, hold_next;
  logic prev_reg, prev_next;
  logic start_reg, start_next;
  logic [127:0] cin_reg, cin_next;
  logic core_done;
  logic [127:0] core_res;
  logic [127:0] core_inv;
  logic wr_ok;
  logic rd_ok;
  logic start_fire;
  logic [5:0] key_len;
  logic [7:0] wbyte;
  logic [7:0] res_byte;
  logic [7:0] chain_byte;
  logic [7:0] out_byte;

  assign wr_ok = avs_write && !wait_reg && avs_byteenable[0];
  assign rd_ok = avs_read && !wait_reg;
  assign wbyte = avs_writedata[7:0];
  assign res_byte = res_reg[127-8*rd_cnt_reg -: 8];
  assign chain_byte = chain_reg[127-8*rd_cnt_reg -: 8];

  // Key bytes needed before a block may start; the reserved code acts as 16
  always_comb begin
    unique case (key_length_select_reg)
      KEY_192: key_len = KEY_LEN_192;
      KEY_256: key_len = KEY_LEN_256;
      default: key_len = KEY_LEN_128;
    endcase
  end

  // Result byte through the selected output path
  always_comb begin
    unique case (dpc_reg[OUTSEL_MSB:OUTSEL_LSB])
      OUT_XOR: out_byte = res_byte ^ chain_byte;
      OUT_INV_KEY: out_byte = core_inv[127-8*rd_cnt_reg -: 8];
      default: out_byte = res_byte;
    endcase
  end

  assign start_fire = en_reg && !busy_reg && !start_reg && bin_cnt_reg == BLOCK_CNT &&
                      kin_cnt_reg >= key_len;

  // One wait cycle per access; read data is caught on the first edge
  always_comb begin
    wait_next = 1'b1;
    rdata_next = rdata_reg;
    if ((avs_read || avs_write) && wait_reg) begin
      wait_next = 1'b0;
      rdata_next = '0;
      if (avs_read) begin
        case (avs_address)
          IDX_BLOCK_CFG: rdata_next[5:0] = {done_reg, busy_reg, en_reg, enc_reg, key_length_select_reg};
          IDX_DATA_CFG: rdata_next[2:0] = dpc_reg;
          IDX_RESULT: rdata_next[7:0] = out_byte;
          default: rdata_next = '0;
        endcase
      end
    end
  end

  // Register writes, byte gathering, start and completion
  always_comb begin
    key_length_select_next = key_length_select_reg;
    enc_next = enc_reg;
    en_next = en_reg;
    busy_next = busy_reg;
    done_next = done_reg;
    dpc_next = dpc_reg;
    bin_next = bin_reg;
    bin_cnt_next = bin_cnt_reg;
    chain_next = chain_reg;
    xin_cnt_next = xin_cnt_reg;
    key_next = key_reg;
    kin_cnt_next = kin_cnt_reg;
    res_next = res_reg;
    rd_cnt_next = rd_cnt_reg;
    hold_next = hold_reg;
    prev_next = prev_reg;
    start_next = 1'b0;
    cin_next = cin_reg;
    if (wr_ok) begin
      case (avs_address)
        IDX_BLOCK_CFG: begin
          key_length_select_next = wbyte[KEY_LENGTH_SELECT_MSB:KEY_LENGTH_SELECT_LSB];
          enc_next = wbyte[DIR_BIT];
          en_next = wbyte[EN_BIT];
          done_next = done_reg & wbyte[DONE_BIT];
          // A running block still finishes; the byte streams restart and the link to the previous block is dropped
          if (!wbyte[EN_BIT]) begin
            bin_cnt_next = '0;
            xin_cnt_next = '0;
            kin_cnt_next = '0;
            rd_cnt_next = '0;
            prev_next = 1'b0;
          end
        end
        IDX_DATA_CFG: dpc_next = wbyte[2:0];
        IDX_BLOCK_IN: begin
          if (en_reg && !busy_reg && bin_cnt_reg < BLOCK_CNT) begin
            bin_next[127-8*bin_cnt_reg -: 8] = wbyte;
            bin_cnt_next = bin_cnt_reg + 5'h1;
            // First byte of a further block: previous ciphertext becomes chain
            if (bin_cnt_reg == 5'h0 && prev_reg) begin
              chain_next = enc_reg ? res_reg : hold_reg;
              xin_cnt_next = '0;
              prev_next = 1'b0;
            end
          end
        end
        IDX_CHAIN_IN: begin
          chain_next[127-8*xin_cnt_reg -: 8] = wbyte;
          xin_cnt_next = xin_cnt_reg + 4'h1;
        end
        IDX_KEY_IN: begin
          if (en_reg && !busy_reg && kin_cnt_reg < KEY_LEN_256) begin
            key_next[255-8*kin_cnt_reg -: 8] = wbyte;
            kin_cnt_next = kin_cnt_reg + 6'h1;
          end
        end
        default: ;
      endcase
    end
    if (rd_ok && avs_address == IDX_RESULT) rd_cnt_next = rd_cnt_reg + 4'h1;
    if (start_fire) begin
      start_next = 1'b1;
      busy_next = 1'b1;
      bin_cnt_next = '0;
      kin_cnt_next = '0;
      hold_next = bin_reg;
      cin_next = dpc_reg[XORIN_BIT] ? bin_reg ^ chain_reg : bin_reg;
    end
    // Completion wins over a software clear in the same cycle
    if (core_done) begin
      res_next = core_res;
      busy_next = 1'b0;
      done_next = 1'b1;
      prev_next = 1'b1;
      rd_cnt_next = '0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      wait_reg <= 1'b1;
      rdata_reg <= '0;
      key_length_select_reg <= CFG_RESET[KEY_LENGTH_SELECT_MSB:KEY_LENGTH_SELECT_LSB];
      enc_reg <= CFG_RESET[DIR_BIT];
      en_reg <= CFG_RESET[EN_BIT];
      busy_reg <= CFG_RESET[BUSY_BIT];
      done_reg <= CFG_RESET[DONE_BIT];
      dpc_reg <= DPC_RESET;
      bin_reg <= '0;
      bin_cnt_reg <= '0;
      chain_reg <= '0;
      xin_cnt_reg <= '0;
      key_reg <= '0;
      kin_cnt_reg <= '0;
      res_reg <= '0;
      rd_cnt_reg <= '0;
      hold_reg <= '0;
      prev_reg <= 1'b0;
      start_reg <= 1'b0;
      cin_reg <= '0;
    end else begin
      wait_reg <= wait_next;
      rdata_reg <= rdata_next;
      key_length_select_reg <= key_length_select_next;
      enc_reg <= enc_next;
      en_reg <= en_next;
      busy_reg <= busy_next;
      done_reg <= done_next;
      dpc_reg <= dpc_next;
      bin_reg <= bin_next;
      bin_cnt_reg <= bin_cnt_next;
      chain_reg <= chain_next;
      xin_cnt_reg <= xin_cnt_next;
      key_reg <= key_next;
      kin_cnt_reg <= kin_cnt_next;
      res_reg <= res_next;
      rd_cnt_reg <= rd_cnt_next;
      hold_reg <= hold_next;
      prev_reg <= prev_next;
      start_reg <= start_next;
      cin_reg <= cin_next;
    end
  end

  aes_round_core u_core (
    .core_clk(core_clk),
    .reset(reset),
    .start(start_reg),
    .encrypt(enc_reg),
    .key_mode(key_length_select_reg),
    .key(key_reg),
    .block_in(cin_reg),
    .result(core_res),
    .inv_key(core_inv),
    .done(core_done)
  );

  assign avs_waitrequest = wait_reg;
  assign avs_readdata = rdata_reg;
  assign done_out = done_reg;
  assign busy_out = busy_reg;

  a_input_xor_path: assert property (
    @(posedge core_clk) disable iff (reset)
    start_fire && dpc_reg == DPC_CBC_ENC |=> cin_reg == $past(bin_reg ^ chain_reg))
    else $error("core input is not block xor chain");

  a_output_xor_path: assert property (
    @(posedge core_clk) disable iff (reset)
    avs_read && wait_reg && avs_address == IDX_RESULT && dpc_reg == DPC_CBC_DEC
    |=> avs_readdata[7:0] == $past(res_byte ^ chain_byte))
    else $error("result byte is not core output xor chain");

  a_start_needs_enable: assert property (
    @(posedge core_clk) disable iff (reset)
    $rose(start_reg) |-> $past(en_reg) && $past(bin_cnt_reg) == BLOCK_CNT)
    else $error("block started without enable or full input");

  a_key_length_met: assert property (
    @(posedge core_clk) disable iff (reset)
    start_fire |-> kin_cnt_reg >= ((key_length_select_reg == KEY_256) ? KEY_LEN_256 :
                   (key_length_select_reg == KEY_192) ? KEY_LEN_192 : KEY_LEN_128))
    else $error("block started with too few key bytes");

  a_zero_write_reset: assert property (
    @(posedge core_clk) disable iff (reset)
    wr_ok && avs_address == IDX_BLOCK_CFG && wbyte == CFG_RESET && !core_done
    |=> !en_reg && !done_reg && bin_cnt_reg == 5'h0 && kin_cnt_reg == 6'h0)
    else $error("zero write did not reset the module");

  a_done_on_finish: assert property (
    @(posedge core_clk) disable iff (reset)
    core_done |=> done_reg && !busy_reg && rd_cnt_reg == 4'h0)
    else $error("completion did not raise done");

  a_result_order: assert property (
    @(posedge core_clk) disable iff (reset)
    rd_ok && avs_address == IDX_RESULT && !core_done
    |=> rd_cnt_reg == $past(rd_cnt_reg) + 4'h1)
    else $error("result index did not advance by one");

  a_chain_previous: assert property (
    @(posedge core_clk) disable iff (reset)
    wr_ok && avs_address == IDX_BLOCK_IN && en_reg && !busy_reg && enc_reg &&
    bin_cnt_reg == 5'h0 && prev_reg |=> chain_reg == $past(res_reg))
    else $error("ciphertext not chained into next block");

  a_done_sticky: assert property (
    @(posedge core_clk) disable iff (reset)
    done_reg && !(wr_ok && avs_address == IDX_BLOCK_CFG) |=> done_reg)
    else $error("done fell without a software write");

  a_busy_span: assert property (
    @(posedge core_clk) disable iff (reset)
    start_fire |=> busy_reg ##[10:90] !busy_reg && done_reg)
    else $error("busy span of a block is wrong");
endmodule

/* aes_cbc_pkg.sv */
package aes_cbc_pkg;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 3;
  localparam int BE_W = 4;
  // Word indexes; the byte address is four times the index
  localparam logic [2:0] IDX_BLOCK_CFG = 3'h0;
  localparam logic [2:0] IDX_DATA_CFG = 3'h1;
  localparam logic [2:0] IDX_BLOCK_IN = 3'h2;
  localparam logic [2:0] IDX_CHAIN_IN = 3'h3;
  localparam logic [2:0] IDX_KEY_IN = 3'h4;
  localparam logic [2:0] IDX_RESULT = 3'h5;
  // Block configuration fields
  localparam int KEY_LENGTH_SELECT_LSB = 0;
  localparam int KEY_LENGTH_SELECT_MSB = 1;
  localparam int DIR_BIT = 2;
  localparam int EN_BIT = 3;
  localparam int BUSY_BIT = 4;
  localparam int DONE_BIT = 5;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [1:0] KEY_128 = 2'h0;
  localparam logic [1:0] KEY_192 = 2'h1;
  localparam logic [1:0] KEY_256 = 2'h2;
  localparam logic [5:0] KEY_LEN_128 = 6'h10;
  localparam logic [5:0] KEY_LEN_192 = 6'h18;
  localparam logic [5:0] KEY_LEN_256 = 6'h20;
  // Data path configuration fields
  localparam int XORIN_BIT = 0;
  localparam int OUTSEL_LSB = 1;
  localparam int OUTSEL_MSB = 2;
  localparam logic [2:0] DPC_RESET = 3'h0;
  localparam logic [2:0] DPC_CBC_ENC = 3'h1;
  localparam logic [2:0] DPC_CBC_DEC = 3'h2;
  localparam logic [1:0] OUT_DIRECT = 2'h0;
  localparam logic [1:0] OUT_XOR = 2'h1;
  localparam logic [1:0] OUT_INV_KEY = 2'h2;
  localparam logic [4:0] BLOCK_CNT = 5'h10;
  localparam logic [3:0] NK_128 = 4'h4;
  localparam logic [3:0] NK_192 = 4'h6;
  localparam logic [3:0] NK_256 = 4'h8;
  localparam logic [3:0] NR_EXTRA = 4'h6;
  localparam logic [7:0] RCON_FIRST = 8'h01;
  typedef enum logic [1:0] {CORE_IDLE, CORE_EXPAND, CORE_ROUND} core_state_t;
endpackage

/* aes_round_core.sv */
`timescale 1ns/100ps
module aes_round_core (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic start,
  input wire logic encrypt,
  input wire logic [1:0] key_mode,
  input wire logic [255:0] key,
  input wire logic [127:0] block_in,
  output logic [127:0] result,
  output logic [127:0] inv_key,
  output logic done
);
  import aes_cbc_pkg::*;

  function automatic logic [7:0] gmul(input logic [7:0] a, input logic [7:0] b);
    logic [7:0] p;
    logic [7:0] x;
    p = 8'h00;
    x = a;
    for (int i = 0; i < 8; i++) begin
      if (b[i]) p = p ^ x;
      x = {x[6:0], 1'b0} ^ (x[7] ? 8'h1B : 8'h00);
    end
    return p;
  endfunction

  // Field inverse as x^254; zero maps to zero
  function automatic logic [7:0] ginv(input logic [7:0] x);
    logic [7:0] r;
    r = x;
    for (int i = 0; i < 6; i++) r = gmul(gmul(r, r), x);
    return gmul(r, r);
  endfunction

  function automatic logic [7:0] rotl(input logic [7:0] x, input int n);
    return 8'((x << n) | (x >> (8 - n)));
  endfunction

  // Computed rather than tabled: smaller source, larger gates
  function automatic logic [7:0] sbox(input logic [7:0] x);
    logic [7:0] b;
    b = ginv(x);
    return b ^ rotl(b, 1) ^ rotl(b, 2) ^ rotl(b, 3) ^ rotl(b, 4) ^ 8'h63;
  endfunction

  function automatic logic [7:0] isbox(input logic [7:0] x);
    return ginv(rotl(x, 1) ^ rotl(x, 3) ^ rotl(x, 6) ^ 8'h05);
  endfunction

  function automatic logic [31:0] subw(input logic [31:0] w);
    return {sbox(w[31:24]), sbox(w[23:16]), sbox(w[15:8]), sbox(w[7:0])};
  endfunction

  function automatic logic [127:0] enc_round(input logic [127:0] s, input logic [127:0] k,
                                             input logic last);
    logic [7:0] t [16];
    logic [127:0] o;
    o = '0;
    for (int j = 0; j < 16; j++) t[j] = sbox(s[127-8*(4*((j/4+j%4)%4)+j%4) -: 8]);
    for (int c = 0; c < 4; c++) begin
      if (last) o[127-32*c -: 32] = {t[4*c], t[4*c+1], t[4*c+2], t[4*c+3]};
      else o[127-32*c -: 32] = {
        gmul(t[4*c], 8'h02) ^ gmul(t[4*c+1], 8'h03) ^ t[4*c+2] ^ t[4*c+3],
        t[4*c] ^ gmul(t[4*c+1], 8'h02) ^ gmul(t[4*c+2], 8'h03) ^ t[4*c+3],
        t[4*c] ^ t[4*c+1] ^ gmul(t[4*c+2], 8'h02) ^ gmul(t[4*c+3], 8'h03),
        gmul(t[4*c], 8'h03) ^ t[4*c+1] ^ t[4*c+2] ^ gmul(t[4*c+3], 8'h02)};
    end
    return o ^ k;
  endfunction

  function automatic logic [127:0] dec_round(input logic [127:0] s, input logic [127:0] k,
                                             input logic last);
    logic [127:0] u;
    logic [127:0] o;
    logic [7:0] a [4];
    for (int j = 0; j < 16; j++)
      u[127-8*j -: 8] = isbox(s[127-8*(4*((j/4-j%4+4)%4)+j%4) -: 8]);
    u = u ^ k;
    o = u;
    for (int c = 0; c < 4; c++) begin
      for (int r = 0; r < 4; r++) a[r] = u[127-32*c-8*r -: 8];
      if (!last) o[127-32*c -: 32] = {
        gmul(a[0], 8'h0E) ^ gmul(a[1], 8'h0B) ^ gmul(a[2], 8'h0D) ^ gmul(a[3], 8'h09),
        gmul(a[0], 8'h09) ^ gmul(a[1], 8'h0E) ^ gmul(a[2], 8'h0B) ^ gmul(a[3], 8'h0D),
        gmul(a[0], 8'h0D) ^ gmul(a[1], 8'h09) ^ gmul(a[2], 8'h0E) ^ gmul(a[3], 8'h0B),
        gmul(a[0], 8'h0B) ^ gmul(a[1], 8'h0D) ^ gmul(a[2], 8'h09) ^ gmul(a[3], 8'h0E)};
    end
    return o;
  endfunction

  core_state_t st_reg, st_next;
  logic [31:0] w [60];
  logic [5:0] idx_reg, idx_next;
  logic [3:0] pos_reg, pos_next;
  logic [3:0] rnd_reg, rnd_next;
  logic [3:0] nk_reg, nk_next;
  logic [7:0] rcon_reg, rcon_next;
  logic [127:0] st_data_reg, st_data_next;
  logic [127:0] blk_reg, blk_next;
  logic enc_reg, enc_next;
  logic done_reg, done_next;
  logic [3:0] nr;
  logic [5:0] total;
  logic [31:0] wtmp;
  logic w_we;
  logic [127:0] rk;

  assign nr = nk_reg + NR_EXTRA;
  assign total = {nr + 4'h1, 2'b00};
  assign rk = {w[{rnd_reg, 2'b00}], w[{rnd_reg, 2'b01}], w[{rnd_reg, 2'b10}],
               w[{rnd_reg, 2'b11}]};
  assign inv_key = {w[{nr, 2'b00}], w[{nr, 2'b01}], w[{nr, 2'b10}], w[{nr, 2'b11}]};
  assign result = st_data_reg;
  assign done = done_reg;

  // Key schedule one word per cycle, then one round per cycle
  always_comb begin
    st_next = st_reg;
    idx_next = idx_reg;
    pos_next = pos_reg;
    rnd_next = rnd_reg;
    nk_next = nk_reg;
    rcon_next = rcon_reg;
    st_data_next = st_data_reg;
    blk_next = blk_reg;
    enc_next = enc_reg;
    done_next = 1'b0;
    w_we = 1'b0;
    wtmp = w[idx_reg - 6'h1];
    if (pos_reg == 4'h0) begin
      wtmp = subw({wtmp[23:0], wtmp[31:24]}) ^ {rcon_reg, 24'h0};
    end else if (nk_reg == NK_256 && pos_reg == 4'h4) begin
      wtmp = subw(wtmp);
    end
    wtmp = wtmp ^ w[idx_reg - {2'b00, nk_reg}];
    unique case (st_reg)
      CORE_IDLE: begin
        if (start) begin
          st_next = CORE_EXPAND;
          nk_next = (key_mode == KEY_192) ? NK_192 : (key_mode == KEY_256) ? NK_256 : NK_128;
          idx_next = {2'b00, nk_next};
          pos_next = 4'h0;
          rcon_next = RCON_FIRST;
          blk_next = block_in;
          enc_next = encrypt;
        end
      end
      CORE_EXPAND: begin
        if (idx_reg == total) begin
          st_next = CORE_ROUND;
          rnd_next = enc_reg ? 4'h0 : nr;
          st_data_next = blk_reg;
        end else begin
          w_we = 1'b1;
          idx_next = idx_reg + 6'h1;
          pos_next = (pos_reg == nk_reg - 4'h1) ? 4'h0 : pos_reg + 4'h1;
          if (pos_reg == 4'h0) rcon_next = gmul(rcon_reg, 8'h02);
        end
      end
      CORE_ROUND: begin
        if (enc_reg) begin
          // Standard cipher for the chosen key size
          if (rnd_reg == 4'h0) st_data_next = st_data_reg ^ rk;
          else st_data_next = enc_round(st_data_reg, rk, rnd_reg == nr);
          rnd_next = rnd_reg + 4'h1;
          if (rnd_reg == nr) begin
            st_next = CORE_IDLE;
            done_next = 1'b1;
          end
        end else begin
          // Inverse cipher, last round key first
          if (rnd_reg == nr) st_data_next = st_data_reg ^ rk;
          else st_data_next = dec_round(st_data_reg, rk, rnd_reg == 4'h0);
          rnd_next = rnd_reg - 4'h1;
          if (rnd_reg == 4'h0) begin
            st_next = CORE_IDLE;
            done_next = 1'b1;
          end
        end
      end
    endcase
  end

  // Round key store; holds data only, so it takes no reset
  always_ff @(posedge core_clk) begin
    if (st_reg == CORE_IDLE && start) begin
      for (int j = 0; j < 8; j++) w[j] <= key[255-32*j -: 32];
    end else if (w_we) begin
      w[idx_reg] <= wtmp;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      st_reg <= CORE_IDLE;
      idx_reg <= 6'h0;
      pos_reg <= 4'h0;
      rnd_reg <= 4'h0;
      nk_reg <= NK_128;
      rcon_reg <= RCON_FIRST;
      st_data_reg <= 128'h0;
      blk_reg <= 128'h0;
      enc_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      idx_reg <= idx_next;
      pos_reg <= pos_next;
      rnd_reg <= rnd_next;
      nk_reg <= nk_next;
      rcon_reg <= rcon_next;
      st_data_reg <= st_data_next;
      blk_reg <= blk_next;
      enc_reg <= enc_next;
      done_reg <= done_next;
    end
  end
endmodule

/* aes_host_model.sv */
`timescale 1ns/100ps
// Processor side of the register bus, one access at a time
module aes_host_model (
  input wire logic core_clk,
  input wire logic avs_waitrequest,
  output logic [2:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [31:0] avs_writedata,
  output logic [3:0] avs_byteenable
);
  initial begin
    avs_address = 3'h7;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
  end

  // Request held until waitrequest is sampled low; idle lines then toggle
  task automatic xfer(input logic wr, input logic [2:0] a, input logic [7:0] d,
                      input logic [3:0] be);
    @(posedge core_clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= {24'h0, d};
    avs_byteenable <= be;
    @(posedge core_clk);
    while (avs_waitrequest !== 1'b0) @(posedge core_clk);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    avs_address <= ~a;
    avs_writedata <= ~avs_writedata;
  endtask
endmodule

/* aes_cbc_datapath_tb.sv */
`timescale 1ns/100ps
module aes_cbc_datapath_tb;
  import aes_cbc_pkg::*;
  localparam logic [127:0] PT = 128'h00112233445566778899AABBCCDDEEFF;
  localparam logic [127:0] IK = 128'h13111D7FE3944A17F307A78B4D2B30C5;
  logic [127:0] ct [3];
  logic core_clk, reset, avs_read, avs_write, avs_waitrequest, done_out, busy_out, saw_busy;
  logic [2:0] avs_address;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata;
  logic [31:0] exp_q[$];
  logic [127:0] ivv;
  int fails, samples_checked;

  aes_host_model aes_host_model_inst (.core_clk(core_clk), .avs_waitrequest(avs_waitrequest),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable));
  aes_cbc_datapath aes_cbc_datapath_inst (.core_clk(core_clk), .reset(reset),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .done_out(done_out), .busy_out(busy_out));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wrap_up;
    if (fails == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Read data is judged when the access completes, against the oldest note
  always @(posedge core_clk) begin
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0) chk(avs_readdata, exp_q.pop_front());
  end

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    aes_host_model_inst.xfer(1'b1, a, d, 4'hF);
  endtask

  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    exp_q.push_back({24'h0, e});
    aes_host_model_inst.xfer(1'b0, a, 8'h00, 4'hF);
  endtask

  // Interleaved block, chain and key bytes, then extra key bytes, then wait
  // The core expands the cipher key itself, so both directions take the same key
  task automatic run_block(input logic [1:0] ks, input logic [127:0] blk, input bit chain);
    int n;
    for (int i = 0; i < 16; i++) begin
      wr(IDX_BLOCK_IN, blk[127-8*i -: 8]);
      if (chain) wr(IDX_CHAIN_IN, ivv[127-8*i -: 8]);
      wr(IDX_KEY_IN, 8'(i));
    end
    for (int i = 16; i < 16 + 8 * ks; i++) wr(IDX_KEY_IN, 8'(i));
    saw_busy = 1'b0;
    n = 0;
    while (done_out !== 1'b1 && n < 400) begin
      @(posedge core_clk);
      if (busy_out === 1'b1) saw_busy = 1'b1;
      n++;
    end
    chk({31'h0, saw_busy}, 32'h1);
    chk({31'h0, busy_out}, 32'h0);
  endtask

  // Limit far beyond the expected run of about fifteen hundred cycles
  initial begin
    repeat (20000) @(posedge core_clk);
    fails++;
    wrap_up;
  end

  initial begin
    ct[0] = 128'h69C4E0D86A7B0430D8CDB78070B4C55A;
    ct[1] = 128'hDDA97CA4864CDFE06EAF70A0EC0D7191;
    ct[2] = 128'h8EA2B7CA516745BFEAFC49904B496089;
    reset = 1'b1;
    void'($urandom(32'hD94FDF47));
    repeat (16) @(posedge core_clk);
    reset <= 1'b0;
    rd(IDX_BLOCK_CFG, 8'h00);
    wr(3'h6, 8'hFF);
    rd(3'h6, 8'h00);
    // Chained encryption for every key size, random IV folded into the block
    for (int ks = 0; ks < 3; ks++) begin
      for (int i = 0; i < 4; i++) ivv[32*i +: 32] = $urandom;
      wr(IDX_BLOCK_CFG, 8'h00);
      wr(IDX_DATA_CFG, 8'(DPC_CBC_ENC));
      aes_host_model_inst.xfer(1'b1, IDX_BLOCK_CFG, 8'h0F, 4'h0);
      rd(IDX_BLOCK_CFG, 8'h00);
      wr(IDX_BLOCK_CFG, 8'h0C | 8'(ks));
      run_block(2'(ks), PT ^ ivv, 1'b1);
      rd(IDX_BLOCK_CFG, 8'h2C | 8'(ks));
      for (int i = 0; i < 16; i++) rd(IDX_RESULT, ct[ks][127-8*i -: 8]);
    end
    // Next block with no chain writes must take the last ciphertext
    wr(IDX_BLOCK_CFG, 8'h0E);
    rd(IDX_BLOCK_CFG, 8'h0E);
    run_block(2'h2, PT ^ ct[2], 1'b0);
    rd(IDX_DATA_CFG, 8'(DPC_CBC_ENC));
    for (int i = 0; i < 16; i++) rd(IDX_RESULT, ct[2][127-8*i -: 8]);
    // Decryption: chain bytes written after completion, XORed at the output
    wr(IDX_BLOCK_CFG, 8'h00);
    wr(IDX_DATA_CFG, 8'(DPC_CBC_DEC));
    wr(IDX_BLOCK_CFG, 8'h08);
    run_block(2'h0, ct[0], 1'b0);
    rd(IDX_BLOCK_CFG, 8'h28);
    for (int i = 0; i < 16; i++) begin
      wr(IDX_CHAIN_IN, ivv[127-8*i -: 8]);
      rd(IDX_RESULT, PT[127-8*i -: 8] ^ ivv[127-8*i -: 8]);
    end
    // Output select 10 shows the last round key of the schedule just used
    wr(IDX_DATA_CFG, 8'h04);
    for (int i = 0; i < 16; i++) rd(IDX_RESULT, IK[127-8*i -: 8]);
    wr(IDX_BLOCK_CFG, 8'h00);
    rd(IDX_BLOCK_CFG, 8'h00);
    chk({31'h0, done_out}, 32'h0);
    wrap_up;
  end
endmodule
